// ### bench/rom_loader_sva.sv
`timescale 1ns/1ps
// Port checks on the loader
module rom_loader_sva
(
    // Watched ports
    input wire       clk_sys_in,
    input wire       arst_n_in,
    input wire       rom_req_out,
    input wire [7:0] rom_addr_out,
    input wire       rom_ack_in,
    input wire [7:0] rom_data_in,
    input wire       cfg_wr_out,
    input wire [7:0] cfg_offset_out,
    input wire [7:0] cfg_data_out,
    input wire [7:0] cfg_mask_out,
    input wire       cfg_done_in,
    input wire       busy_out,
    input wire       error_out,
    input wire       done_out
);
    reg  [7:0] last_r;
    wire       take = rom_req_out && rom_ack_in;
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!arst_n_in);
    // Address of the last byte taken
    always @(posedge clk_sys_in or negedge arst_n_in)
        if (!arst_n_in)
            last_r <= 8'h00;
        else if (take)
            last_r <= rom_addr_out;
    a_addr_ascend: assert property (
        rom_req_out && rom_addr_out != 8'h4e |-> rom_addr_out == last_r + 8'h01)
        else $error("fetch address skipped");
    a_wr_hold: assert property (cfg_wr_out && !cfg_done_in |=>
        cfg_wr_out && $stable(cfg_offset_out) && $stable(cfg_mask_out))
        else $error("write not held");
    a_wr_alone: assert property (
        cfg_wr_out |-> !rom_req_out && busy_out
        && rom_addr_out inside {[8'h53:8'h60]}) else $error("stray write");
    a_class_map: assert property (cfg_wr_out && rom_addr_out < 8'h56
        |-> cfg_offset_out == rom_addr_out - 8'h4a) else $error("class map");
    a_subsys_map: assert property (
        cfg_wr_out && rom_addr_out inside {[8'h56:8'h59]}
        |-> cfg_offset_out == rom_addr_out - 8'h2a) else $error("subsys map");
    a_genctl_mask: assert property (
        cfg_wr_out && cfg_offset_out == 8'h4c
        |-> cfg_mask_out == 8'hf0 && (cfg_data_out & 8'h0f) == 8'h00)
        else $error("genctl mask");
    a_sc1_mask: assert property (
        cfg_wr_out && cfg_offset_out inside {[8'h58:8'h5a]}
        |-> cfg_mask_out == 8'h11) else $error("sc1 mask");
    a_sc1_top: assert property (
        cfg_wr_out && cfg_offset_out == 8'h5b
        |-> cfg_mask_out == 8'hf1) else $error("sc1 top mask");
    a_marker_end: assert property (take && rom_addr_out == 8'h61
        && rom_data_in == 8'h80 |-> ##[1:3] done_out && !busy_out)
        else $error("no end");
    a_bad_ind: assert property (take && rom_addr_out == 8'h51
        && rom_data_in != 8'h04 |-> ##[1:3] error_out && !busy_out)
        else $error("bad group kept");
    a_bad_count: assert property (take && rom_addr_out == 8'h52
        && rom_data_in != 8'h0e |-> ##[1:3] error_out && !busy_out)
        else $error("bad count kept");
endmodule // rom_loader_sva

// ### bench/rom_model.sv
`timescale 1ns/1ps
// Serial ROM answering byte fetches
module rom_model
(
    // Fetch port
    input  wire       clk_sys_in,
    input  wire       req_in,
    input  wire [7:0] addr_in,
    input  wire [1:0] lat_in,
    output reg        ack_out = 1'b0,
    output reg  [7:0] data_out = 8'h00
);
    reg [7:0] mem [0:255];
    reg [1:0] wait_r = 2'h0;
    integer   fetches = 0;
    // Answer after lat_in idle cycles, scramble bus otherwise
    always @(posedge clk_sys_in)
    begin
        ack_out <= 1'b0;
        data_out <= ~data_out;
        wait_r <= 2'h0;
        if (req_in && !ack_out && wait_r < lat_in)
            wait_r <= wait_r + 2'h1;
        else if (req_in && !ack_out)
        begin
            ack_out <= 1'b1;
            data_out <= mem[addr_in];
            fetches <= fetches + 1;
        end
    end
endmodule // rom_model

// ### bench/testbench.sv
`timescale 1ns/1ps
module testbench;
    reg        clk_sys_in = 1'b0;
    reg        arst_n_in = 1'b1; // Lowered by run at a falling edge
    reg        start_in = 1'b0;
    reg        cfg_done_in = 1'b0;
    reg  [1:0] lat = 2'h0;
    reg  [7:0] img [0:255];
    reg  [15:0] m;
    wire       rom_req_out, rom_ack_in, cfg_wr_out;
    wire       busy_out, done_out, error_out;
    wire [7:0] rom_addr_out, rom_data_in, cfg_offset_out;
    wire [7:0] cfg_data_out, cfg_mask_out;
    integer    err_total = 0, comparisons = 0, cycles = 0, writes = 0, i, j;
    rom_config_loader u_dut(.clk_sys_in(clk_sys_in), .arst_n_in(arst_n_in),
        .start_in(start_in), .rom_req_out(rom_req_out),
        .rom_addr_out(rom_addr_out), .rom_ack_in(rom_ack_in),
        .rom_data_in(rom_data_in), .cfg_wr_out(cfg_wr_out),
        .cfg_offset_out(cfg_offset_out), .cfg_data_out(cfg_data_out),
        .cfg_mask_out(cfg_mask_out), .cfg_done_in(cfg_done_in),
        .busy_out(busy_out), .done_out(done_out), .error_out(error_out));
    rom_model u_rom(.clk_sys_in(clk_sys_in), .req_in(rom_req_out), .lat_in(lat),
        .addr_in(rom_addr_out), .ack_out(rom_ack_in), .data_out(rom_data_in));
    always #4 clk_sys_in = ~clk_sys_in;
    // Target acknowledges each write half a cycle later, at the falling edge
    always @(negedge clk_sys_in)
        cfg_done_in <= cfg_wr_out && !cfg_done_in;
    // Merge writes into the image, cut hangs short
    always @(posedge clk_sys_in)
    begin
        cycles <= cycles + 1;
        if (cfg_wr_out && cfg_done_in)
        begin
            img[cfg_offset_out] <= (img[cfg_offset_out] & ~cfg_mask_out)
                | (cfg_data_out & cfg_mask_out);
            writes <= writes + 1;
        end
        if (cycles == 5000)
        begin
            err_total = err_total + 1;
            end_sim;
        end
    end
    // Config offset and mask expected for a ROM byte
    function [15:0] om(input [7:0] a);
        case (a)
            8'h5a: om = {8'h4c, 8'hf0};
            8'h5b, 8'h5c, 8'h5d: om = {a - 8'h03, 8'h11};
            8'h5e: om = {8'h5b, 8'hf1};
            8'h5f, 8'h60: om = {a - 8'h03, 8'hff};
            default: om = {a - (a > 8'h55 ? 8'h2a : 8'h4a), 8'hff};
        endcase
    endfunction
    task cmp(input [63:0] what, input [7:0] exp, input [7:0] got);
    begin
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            err_total = err_total + 1;
            $display("Error %0s expected %h seen %h", what, exp, got);
        end
    end
    endtask
    // Reset, fill ROM and image, then load with start held for three cycles
    task run(input [7:0] a, input [7:0] v);
    begin
        @(negedge clk_sys_in);
        arst_n_in = 1'b0;
        for (i = 0; i < 256; i = i + 1)
        begin
            img[i] = 8'haa;
            u_rom.mem[i] = i[7:0] ^ 8'h5c;
        end
        u_rom.mem[8'h51] = 8'h04;
        u_rom.mem[8'h52] = 8'h0e;
        u_rom.mem[8'h61] = 8'h80;
        u_rom.mem[a] = v;
        writes = 0;
        u_rom.fetches = 0;
        repeat (3) @(negedge clk_sys_in);
        cmp("reset", 8'h00, {3'h0, rom_req_out, cfg_wr_out, busy_out,
            done_out, error_out});
        arst_n_in = 1'b1;
        start_in = 1'b1;
        repeat (3) @(negedge clk_sys_in);
        cmp("busy", 8'h01, {7'h00, busy_out});
        start_in = 1'b0;
        for (i = 0; i < 400 && !done_out && !error_out; i = i + 1)
            @(negedge clk_sys_in);
        repeat (5) @(negedge clk_sys_in);
    end
    endtask
    task t_good(input [1:0] l);
    begin
        lat = l;
        run(8'h00, 8'h5c);
        cmp("done", 8'h01, {7'h00, done_out});
        cmp("busy", 8'h00, {7'h00, busy_out});
        cmp("fetches", 8'h14, u_rom.fetches[7:0]);
        cmp("writes", 8'h0e, writes[7:0]);
        cmp("slot3", 8'haa, img[8'ha0]);
        for (j = 8'h53; j < 8'h61; j = j + 1)
        begin
            m = om(j[7:0]);
            cmp("cfg", (8'haa & ~m[7:0]) | (u_rom.mem[j] & m[7:0]), img[m[15:8]]);
        end
    end
    endtask
    task t_bad;
    begin
        for (j = 0; j < 3; j = j + 1)
        begin
            run(j == 0 ? 8'h51 : j == 1 ? 8'h52 : 8'h61, j == 2 ? 8'h00 : 8'h05);
            cmp("error", 8'h01, {7'h00, error_out});
            cmp("done", 8'h00, {7'h00, done_out});
            cmp("writes", j == 2 ? 8'h0e : 8'h00, writes[7:0]);
        end
    end
    endtask
    // Load again from the error state without a reset
    task t_restart;
    begin
        u_rom.mem[8'h61] = 8'h80;
        writes = 0;
        u_rom.fetches = 0;
        start_in = 1'b1;
        @(negedge clk_sys_in);
        start_in = 1'b0;
        cmp("busy", 8'h01, {7'h00, busy_out});
        cmp("cleared", 8'h00, {6'h00, done_out, error_out});
        for (i = 0; i < 400 && !done_out && !error_out; i = i + 1)
            @(negedge clk_sys_in);
        repeat (5) @(negedge clk_sys_in);
        cmp("done", 8'h01, {7'h00, done_out});
        cmp("error", 8'h00, {7'h00, error_out});
        cmp("fetches", 8'h14, u_rom.fetches[7:0]);
        cmp("writes", 8'h0e, writes[7:0]);
    end
    endtask
    task end_sim;
    begin
        if (err_total == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    end
    endtask
    initial
    begin
        t_good(2'h0);
        t_good(2'h3);
        t_bad;
        t_restart;
        end_sim;
    end
endmodule // testbench
bind rom_config_loader rom_loader_sva u_sva(.clk_sys_in(clk_sys_in),
    .arst_n_in(arst_n_in), .rom_req_out(rom_req_out), .rom_ack_in(rom_ack_in),
    .rom_addr_out(rom_addr_out), .rom_data_in(rom_data_in),
    .cfg_wr_out(cfg_wr_out), .cfg_offset_out(cfg_offset_out),
    .cfg_data_out(cfg_data_out), .cfg_mask_out(cfg_mask_out),
    .cfg_done_in(cfg_done_in), .busy_out(busy_out), .error_out(error_out),
    .done_out(done_out));

// ### src/rom_byte_map.v
`timescale 1ns/1ps
`include "rom_loader_defines.vh"
// Maps a ROM address to target offset and write mask, registered
module rom_byte_map
(
    // Clock and reset
    input  wire       clk_sys_in,
    input  wire       arst_n_in,
    // Lookup request
    input  wire [7:0] rom_addr_in,
    // Registered result
    output reg  [7:0] cfg_offset_out,
    output reg  [7:0] cfg_mask_out,
    output reg        cfg_valid_out
);
    reg [7:0] off_nxt;
    reg [7:0] mask_nxt;
    reg       valid_nxt;

    // Table of target bytes for the smart card group
    always @*
    begin
        off_nxt   = 8'h00;
        mask_nxt  = 8'h00;
        valid_nxt = 1'b0;
        if (rom_addr_in >= `ROM_CLASS0_ADDR &&
            rom_addr_in < `ROM_SUBSYS0_ADDR)
        begin
            off_nxt   = `CFG_CLASS0
                        + (rom_addr_in - `ROM_CLASS0_ADDR);
            mask_nxt  = `MASK_FULL;
            valid_nxt = 1'b1;
        end
        else if (rom_addr_in >= `ROM_SUBSYS0_ADDR &&
                 rom_addr_in < `ROM_GENCTL_ADDR)
        begin
            off_nxt   = `CFG_SUBSYS0
                        + (rom_addr_in - `ROM_SUBSYS0_ADDR);
            mask_nxt  = `MASK_FULL;
            valid_nxt = 1'b1;
        end
        else if (rom_addr_in == `ROM_GENCTL_ADDR)
        begin
            off_nxt   = `CFG_GENCTL;
            mask_nxt  = `MASK_GENCTL;
            valid_nxt = 1'b1;
        end
        else if (rom_addr_in >= `ROM_SC1B0_ADDR &&
                 rom_addr_in < `ROM_SC1B3_ADDR)
        begin
            off_nxt   = `CFG_SC1B0
                        + (rom_addr_in - `ROM_SC1B0_ADDR);
            mask_nxt  = `MASK_SC1_LOW;
            valid_nxt = 1'b1;
        end
        else if (rom_addr_in == `ROM_SC1B3_ADDR)
        begin
            off_nxt   = `CFG_SC1B3;
            mask_nxt  = `MASK_SC1_B3;
            valid_nxt = 1'b1;
        end
        else if (rom_addr_in == `ROM_SC2B0_ADDR ||
                 rom_addr_in == `ROM_SC2B1_ADDR)
        begin
            off_nxt   = `CFG_SC2B0
                        + (rom_addr_in - `ROM_SC2B0_ADDR);
            mask_nxt  = `MASK_FULL;
            valid_nxt = 1'b1;
        end
    end

    // Register the lookup
    always @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cfg_offset_out <= 8'h00;
            cfg_mask_out   <= 8'h00;
            cfg_valid_out  <= 1'b0;
        end
        else
        begin
            cfg_offset_out <= off_nxt;
            cfg_mask_out   <= mask_nxt;
            cfg_valid_out  <= valid_nxt;
        end
    end
endmodule // rom_byte_map

// ### src/rom_config_loader.v
`timescale 1ns/1ps
`include "rom_loader_defines.vh"
// Smart card part of the serial ROM configuration loader
module rom_config_loader
(
    // Clock and reset
    input  wire       clk_sys_in,
    input  wire       arst_n_in,
    // Start of loading
    input  wire       start_in,
    // ROM byte fetch port
    output wire       rom_req_out,
    output reg  [7:0] rom_addr_out,
    input  wire       rom_ack_in,
    input  wire [7:0] rom_data_in,
    // Config register write port
    output reg        cfg_wr_out,
    output reg  [7:0] cfg_offset_out,
    output reg  [7:0] cfg_data_out,
    output reg  [7:0] cfg_mask_out,
    input  wire       cfg_done_in,
    // Status
    output wire       busy_out,
    output reg        done_out,
    output reg        error_out
);
    localparam [2:0] ST_IDLE  = 3'd0;
    localparam [2:0] ST_FETCH = 3'd1;
    localparam [2:0] ST_MAP   = 3'd2;
    localparam [2:0] ST_WRITE = 3'd3;
    localparam [2:0] ST_DONE  = 3'd4;

    reg  [2:0] state_r;
    reg  [7:0] byte_r;
    wire [7:0] map_offset;
    wire [7:0] map_mask;
    wire       map_valid;

    // Address to target lookup
    rom_byte_map u_map
    (
        .clk_sys_in     (clk_sys_in),
        .arst_n_in      (arst_n_in),
        .rom_addr_in    (rom_addr_out),
        .cfg_offset_out (map_offset),
        .cfg_mask_out   (map_mask),
        .cfg_valid_out  (map_valid)
    );

    // Handshake outputs
    assign rom_req_out = (state_r == ST_FETCH);
    assign busy_out    = (state_r != ST_IDLE) &&
                         (state_r != ST_DONE);

    ////////////////////////////////////////////////////////////////////////
    // Sequencer
    always @(posedge clk_sys_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_r        <= ST_IDLE;
            rom_addr_out   <= 8'h00;
            byte_r         <= 8'h00;
            cfg_wr_out     <= 1'b0;
            cfg_offset_out <= 8'h00;
            cfg_data_out   <= 8'h00;
            cfg_mask_out   <= 8'h00;
            done_out       <= 1'b0;
            error_out      <= 1'b0;
        end
        else
        begin
            case (state_r)
                ST_IDLE:
                begin
                    if (start_in)
                    begin
                        rom_addr_out <= `ROM_FIRST_ADDR;
                        done_out     <= 1'b0;
                        error_out    <= 1'b0;
                        state_r      <= ST_FETCH;
                    end
                end
                ST_FETCH:
                begin
                    if (rom_ack_in)
                    begin
                        byte_r  <= rom_data_in;
                        state_r <= ST_MAP;
                    end
                end
                ST_MAP:
                begin
                    if (byte_r == `END_MARKER &&
                        rom_addr_out == `ROM_END_ADDR)
                    begin
                        done_out <= 1'b1;
                        state_r  <= ST_DONE;
                    end
                    else if (rom_addr_out <= `ROM_SKIP_LAST)
                    begin
                        rom_addr_out <= rom_addr_out + 8'h01;
                        state_r      <= ST_FETCH;
                    end
                    else if (rom_addr_out == `ROM_IND_ADDR &&
                             byte_r != `SC_FUNC_IND)
                    begin
                        error_out <= 1'b1;
                        state_r   <= ST_DONE;
                    end
                    else if (rom_addr_out == `ROM_CNT_ADDR &&
                             byte_r != `SC_BYTE_COUNT)
                    begin
                        error_out <= 1'b1;
                        state_r   <= ST_DONE;
                    end
                    else if (map_valid)
                    begin
                        cfg_wr_out     <= 1'b1;
                        cfg_offset_out <= map_offset;
                        cfg_data_out   <= byte_r & map_mask;
                        cfg_mask_out   <= map_mask;
                        state_r        <= ST_WRITE;
                    end
                    else if (rom_addr_out >= `ROM_END_ADDR)
                    begin
                        error_out <= 1'b1;
                        state_r   <= ST_DONE;
                    end
                    else
                    begin
                        rom_addr_out <= rom_addr_out + 8'h01;
                        state_r      <= ST_FETCH;
                    end
                end
                ST_WRITE:
                begin
                    if (cfg_done_in)
                    begin
                        cfg_wr_out   <= 1'b0;
                        rom_addr_out <= rom_addr_out + 8'h01;
                        state_r      <= ST_FETCH;
                    end
                end
                ST_DONE:
                begin
                    if (start_in)
                    begin
                        rom_addr_out <= `ROM_FIRST_ADDR;
                        done_out     <= 1'b0;
                        error_out    <= 1'b0;
                        state_r      <= ST_FETCH;
                    end
                end
                default:
                begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // rom_config_loader

// ### src/rom_loader_defines.vh
// Overview of operation
// - A byte 04h read at ROM address 51h opens the smart card group.
// - The byte at ROM address 52h is the smart card group count, 0Eh.
// - ROM bytes 53h-55h load class code bytes 0-2 at config 09h-0Bh.
// - ROM bytes 56h-59h load subsystem vendor and subsystem id, low first.
// - ROM byte 5Ah updates only bits 7-4 of general control at 4Ch.
// - ROM bytes 5Bh-5Dh update only bits 4 and 0 of config 58h-5Ah.
// - ROM byte 5Eh updates only bits 7-4 and 0 of config 5Bh.
// - ROM bytes 5Fh and 60h load config 5Ch and 5Dh in full.
// - Marker 80h at ROM address 61h ends loading and stops fetching.
// - ROM bytes 4Eh-50h are read past and configure nothing.
`ifndef ROM_LOADER_DEFINES_VH
`define ROM_LOADER_DEFINES_VH
`define ROM_FIRST_ADDR    8'h4e
`define ROM_SKIP_LAST     8'h50
`define ROM_IND_ADDR      8'h51
`define ROM_CNT_ADDR      8'h52
`define ROM_CLASS0_ADDR   8'h53
`define ROM_SUBSYS0_ADDR  8'h56
`define ROM_GENCTL_ADDR   8'h5a
`define ROM_SC1B0_ADDR    8'h5b
`define ROM_SC1B3_ADDR    8'h5e
`define ROM_SC2B0_ADDR    8'h5f
`define ROM_SC2B1_ADDR    8'h60
`define ROM_END_ADDR      8'h61
`define SC_FUNC_IND       8'h04
`define SC_BYTE_COUNT     8'h0e
`define END_MARKER        8'h80
`define CFG_CLASS0        8'h09
`define CFG_SUBSYS0       8'h2c
`define CFG_GENCTL        8'h4c
`define CFG_SC1B0         8'h58
`define CFG_SC1B3         8'h5b
`define CFG_SC2B0         8'h5c
`define MASK_FULL         8'hff
`define MASK_GENCTL       8'hf0
`define MASK_SC1_LOW      8'h11
`define MASK_SC1_B3       8'hf1
`endif
